// ---- verilog/icsc_defs.svh ----
`ifndef ICSC_DEFS_SVH
`define ICSC_DEFS_SVH

// status register field positions
`define ICSC_EXT_FLAG 15
`define ICSC_EXT_IE 14
`define ICSC_MAINT 11
`define ICSC_MODE 8
`define ICSC_OVF_FLAG 7
`define ICSC_OVF_IE 6
`define ICSC_MODEL 4
`define ICSC_RATE_HI 3
`define ICSC_RATE_LO 1
`define ICSC_ENABLE 0
// bits that hold software state, and the status reset value
`define ICSC_RW_MASK 16'hc1cf
`define ICSC_STATUS_RST 16'h0000
`define ICSC_PRESET_RST 8'h00
// rate codes
`define ICSC_RATE_STOP 3'h0
`define ICSC_RATE_1M 3'h1
`define ICSC_RATE_100 3'h5
`define ICSC_RATE_EXT 3'h6
`define ICSC_RATE_AUX 3'h7
// timing
`define ICSC_CLK_HZ 40000000
`define ICSC_BASE_HZ 1000000
`define ICSC_PRESCALE (`ICSC_CLK_HZ / `ICSC_BASE_HZ)
`define ICSC_DECADE 10
`endif

// ---- verilog/icsc_pkg.sv ----
package icsc_pkg;
  // processor write to the status word
  typedef struct packed {
    logic en;
    logic [1:0] be;
    logic [15:0] data;
  } icsc_status_wr_t;
  // processor write to the buffer/preset register
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } icsc_preset_wr_t;
endpackage

// ---- verilog/icsc_sync_edge.sv ----
`timescale 1ns/100ps
module icsc_sync_edge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // asynchronous level in
  input wire logic async_in,
  // synchronised edges
  output logic fall,
  output logic rise
);
  logic meta;
  logic sync;
  logic last;

  // two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  // one pulse per edge
  assign fall = last & ~sync;
  assign rise = ~last & sync;
endmodule

// ---- verilog/icsc_div.sv ----
`timescale 1ns/100ps
module icsc_div #(
  parameter int DIV = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // slow-rate enables
  input wire logic tick_in,
  output logic tick_out
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt;

  if (DIV < 2) begin : g_chk
    $error("icsc_div needs DIV of at least 2");
  end

  // count input ticks, wrap at DIV
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= tick_out ? '0 : cnt + 1'b1;
    end
  end

  // same-cycle carry keeps the chain free of added lag
  assign tick_out = tick_in && (cnt == W'(DIV - 1));
endmodule

// ---- verilog/icsc_top.sv ----
`timescale 1ns/100ps
`include "icsc_defs.svh"
module icsc_top import icsc_pkg::*; #(
  parameter int PRESCALE = `ICSC_PRESCALE,
  parameter int DECADE = `ICSC_DECADE,
  parameter logic MODEL_ID = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // processor writes
  input wire icsc_status_wr_t status_wr,
  input wire icsc_preset_wr_t preset_wr,
  // pins
  input wire logic external_event_in_n,
  input wire logic aux_rate_pin,
  // processor reads and request
  output logic [15:0] status_rd,
  output logic [7:0] preset_rd,
  output logic [7:0] counter_rd,
  output logic irq
);
  // MODEL_ID: value arbitrary, tells this variant from its sibling

  // status register state
  logic ext_flag;
  logic ext_ie;
  logic mode;
  logic ovf_flag;
  logic ovf_ie;
  logic [2:0] rate;
  logic enable;
  logic maint_pulse;
  // counting state
  logic [7:0] counter;
  logic [7:0] preset;

  // time base and edges
  logic ext_fall;
  logic aux_rise;
  logic tick_pre;
  logic base;
  logic [4:0] dec;
  logic rate_tick;
  logic step;
  logic ovf;
  logic internal_rate;
  logic [15:0] next_status_rd;

  // byte lane strobes
  logic wr_lo;
  logic wr_hi;
  assign wr_lo = status_wr.en & status_wr.be[0];
  assign wr_hi = status_wr.en & status_wr.be[1];

  if (PRESCALE < 2 || DECADE < 2) begin : g_chk
    $error("icsc_top divide ratios must be at least 2");
  end

  icsc_sync_edge u_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(external_event_in_n),
    .fall(ext_fall),
    .rise()
  );

  icsc_sync_edge u_aux (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(aux_rate_pin),
    .fall(),
    .rise(aux_rise)
  );

  // crystal prescaler to the 1 MHz base
  icsc_div #(.DIV(PRESCALE)) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(1'b1),
    .tick_out(tick_pre)
  );

  // maintenance pulse replaces the base while stopped
  assign base = enable ? tick_pre : maint_pulse;
  assign dec[0] = base;

  // decade chain 100 kHz down to 100 Hz
  for (genvar i = 0; i < 4; i++) begin : g_dec
    icsc_div #(.DIV(DECADE)) u_dec (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick_in(dec[i]),
      .tick_out(dec[i+1])
    );
  end

  always_comb begin
    rate_tick = 1'b0;
    internal_rate = 1'b0;
    unique case (rate)
      `ICSC_RATE_STOP: begin
        rate_tick = 1'b0;
      end
      `ICSC_RATE_EXT: begin
        rate_tick = 1'b0;
      end
      `ICSC_RATE_AUX: begin
        rate_tick = 1'b0;
      end
      default: begin
        internal_rate = 1'b1;
        rate_tick = dec[rate - `ICSC_RATE_1M];
      end
    endcase
  end

  always_comb begin
    if (rate == `ICSC_RATE_EXT) begin
      step = ext_fall;
    end else if (rate == `ICSC_RATE_AUX) begin
      step = enable & aux_rise;
    end else begin
      step = rate_tick;
    end
  end

  // overflow on wrap from all ones
  assign ovf = step && (counter == 8'hff);

  // maintenance bit is a one-cycle strobe, never stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      maint_pulse <= 1'b0;
    end else begin
      // injection only while stopped at an internal rate, 1 MHz to 100 Hz
      maint_pulse <= wr_hi & status_wr.data[`ICSC_MAINT] & ~enable
                     & (rate >= `ICSC_RATE_1M && rate <= `ICSC_RATE_100);
    end
  end

  // external flag; hardware set wins over write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_flag <= 1'b0;
    end else if (ext_fall) begin
      ext_flag <= 1'b1;
    end else if (wr_hi) begin
      ext_flag <= status_wr.data[`ICSC_EXT_FLAG];
    end
  end

  // overflow flag; hardware set wins over write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovf_flag <= 1'b0;
    end else if (ovf) begin
      ovf_flag <= 1'b1;
    end else if (wr_lo) begin
      ovf_flag <= status_wr.data[`ICSC_OVF_FLAG];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_ie <= 1'b0;
      mode <= 1'b0;
    end else if (wr_hi) begin
      ext_ie <= status_wr.data[`ICSC_EXT_IE];
      mode <= status_wr.data[`ICSC_MODE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovf_ie <= 1'b0;
      rate <= `ICSC_RATE_STOP;
    end else if (wr_lo) begin
      ovf_ie <= status_wr.data[`ICSC_OVF_IE];
      rate <= status_wr.data[`ICSC_RATE_HI:`ICSC_RATE_LO];
    end
  end

  // enable drops on crystal single-interval overflow, over a write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable <= 1'b0;
    end else if (ovf && !mode && internal_rate) begin
      enable <= 1'b0;
    end else if (wr_lo) begin
      enable <= status_wr.data[`ICSC_ENABLE];
    end
  end

  // buffer/preset register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      preset <= `ICSC_PRESET_RST;
    end else if (preset_wr.en) begin
      preset <= preset_wr.data;
    end
  end

  // counter: preload while stopped, else count and reload
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      counter <= `ICSC_PRESET_RST;
    end else if (preset_wr.en && !enable) begin
      counter <= preset_wr.data;
    end else if (ovf && (mode || !internal_rate)) begin
      counter <= preset;
    end else if (step) begin
      // one step per tick; running preset write ignored
      counter <= counter + 8'h01;
    end
  end

  // read image; unused and write-only read zero
  always_comb begin
    next_status_rd = 16'h0000;
    next_status_rd[`ICSC_EXT_FLAG] = ext_flag;
    next_status_rd[`ICSC_EXT_IE] = ext_ie;
    next_status_rd[`ICSC_MODE] = mode;
    next_status_rd[`ICSC_OVF_FLAG] = ovf_flag;
    next_status_rd[`ICSC_OVF_IE] = ovf_ie;
    next_status_rd[`ICSC_MODEL] = MODEL_ID;
    next_status_rd[`ICSC_RATE_HI:`ICSC_RATE_LO] = rate;
    next_status_rd[`ICSC_ENABLE] = enable;
  end

  // reads have no side effect; outputs are plain registered copies
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_rd <= `ICSC_STATUS_RST;
      preset_rd <= `ICSC_PRESET_RST;
      counter_rd <= `ICSC_PRESET_RST;
    end else begin
      status_rd <= next_status_rd;
      preset_rd <= preset;
      counter_rd <= counter;
    end
  end

  // level request held while a flag and its interrupt enable stay set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (ext_flag & ext_ie) | (ovf_flag & ovf_ie);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // an overflow seen in single-interval crystal mode
  sequence s_single_ovf;
    ovf && !mode && internal_rate;
  endsequence

  // an overflow seen in repeated mode
  sequence s_repeat_ovf;
    ovf && mode && !(preset_wr.en && !enable);
  endsequence

  // a preset write while stopped
  sequence s_preload;
    preset_wr.en && !enable;
  endsequence

  a_maint_reads_zero: assert property (status_rd[`ICSC_MAINT] == 1'b0)
    else $error("maintenance bit read back nonzero");

  a_unused_zero: assert property ((status_rd & 16'h3620) == 16'h0000)
    else $error("unused status bit read nonzero");

  a_model_bit: assert property (##1 status_rd[`ICSC_MODEL] == MODEL_ID)
    else $error("model bit changed");

  a_ext_flag_set: assert property (ext_fall |-> ##2 status_rd[`ICSC_EXT_FLAG])
    else $error("external flag not set after falling edge");

  a_single_stop: assert property (s_single_ovf |=> !enable ##1 ovf_flag)
    else $error("single interval overflow did not stop");

  a_repeat_reload: assert property (s_repeat_ovf |=> counter == $past(preset))
    else $error("repeat overflow did not reload preset");

  a_ovf_flag: assert property (ovf |=> ovf_flag)
    else $error("overflow flag not set");

  a_irq_raise: assert property ((ovf_flag && ovf_ie) || (ext_flag && ext_ie)
                                |=> irq)
    else $error("interrupt not raised");

  a_irq_clear: assert property (!(ovf_flag && ovf_ie) && !(ext_flag && ext_ie)
                                |=> !irq)
    else $error("interrupt raised with no cause");

  a_preload: assert property (s_preload |=> counter == $past(preset_wr.data))
    else $error("stopped preset write did not load counter");

  a_stop_rate: assert property (rate == `ICSC_RATE_STOP && !preset_wr.en
                                |=> $stable(counter))
    else $error("counter moved with no rate");

  a_run_preset: assert property (preset_wr.en && enable && !step
                                 |=> $stable(counter))
    else $error("running preset write touched counter");

  // a step that neither overflows nor meets a preload
  sequence s_plain_step;
    step && counter != 8'hff && !(preset_wr.en && !enable);
  endsequence

  a_count_step: assert property (s_plain_step |=> counter == $past(counter) + 8'h01)
    else $error("counter did not advance by one");

  a_ext_count: assert property (rate == `ICSC_RATE_EXT && ext_fall && !preset_wr.en
                                && counter != 8'hff
                                |=> counter == $past(counter) + 8'h01)
    else $error("external event did not advance counter");

  a_aux_count: assert property (rate == `ICSC_RATE_AUX && enable && aux_rise
                                && counter != 8'hff
                                |=> counter == $past(counter) + 8'h01)
    else $error("auxiliary edge did not advance counter");

  a_aux_idle: assert property (rate == `ICSC_RATE_AUX && !aux_rise && !preset_wr.en
                               |=> $stable(counter))
    else $error("counter moved with no auxiliary edge");

  a_maint_count: assert property (maint_pulse && !enable && rate == `ICSC_RATE_1M
                                  && !preset_wr.en && counter != 8'hff
                                  |=> counter == $past(counter) + 8'h01)
    else $error("maintenance pulse did not advance counter");

  a_ext_no_stop: assert property (ovf && !internal_rate && !wr_lo
                                  |=> enable == $past(enable))
    else $error("external rate overflow changed enable");

endmodule

// ---- verif/icsc_ext_src.sv ----
`timescale 1ns/100ps
module icsc_ext_src (
  // clock
  input wire logic clk_sys,
  // request for a burst of three events
  input wire logic go,
  // active-low event line, idles high as if pulled up
  output logic ext_n
);
  logic [4:0] step = 5'h0;
  // burst sequencer; low phases last three clocks so a two-stage sync cannot miss them
  always_ff @(posedge clk_sys) begin
    if (go && step == 5'h0) begin
      step <= 5'h12;
    end else if (step != 5'h0) begin
      step <= step - 5'h1;
    end
  end
  // low on steps 17-15, 11-9 and 5-3, high otherwise
  assign ext_n = (step % 5'h6) < 5'h3;
endmodule

// ---- verif/interval_clock_status_control_test.sv ----
`timescale 1ns/100ps
module interval_clock_status_control_test import icsc_pkg::*;;
  typedef struct {int sel; logic [15:0] v;} icsc_note_t;
  logic clk_sys = 1'b0, rst = 1'b1, ext_go = 1'b0, aux_rate_pin = 1'b0, irq, external_event_in_n;
  icsc_status_wr_t status_wr = '0;
  icsc_preset_wr_t preset_wr = '0;
  logic [15:0] status_rd, st_m = 16'h0, rv, seen;
  logic [7:0] preset_rd, counter_rd;
  logic [1:0] rb;
  int err_count = 0, n_compared = 0, t0, per;
  icsc_note_t notes[$];
  icsc_note_t nt;
  string nm[4] = '{"status", "preset", "counter", "irq"};
  icsc_top #(.PRESCALE(4), .DECADE(2), .MODEL_ID(1'b0)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .status_wr(status_wr), .preset_wr(preset_wr), .external_event_in_n(external_event_in_n),
    .aux_rate_pin(aux_rate_pin), .status_rd(status_rd), .preset_rd(preset_rd),
    .counter_rd(counter_rd), .irq(irq));
  icsc_ext_src src_u (.clk_sys(clk_sys), .go(ext_go), .ext_n(external_event_in_n));
  // free-running system clock
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one write pulse, then a released strobe
  task automatic wr_st(logic [1:0] be, logic [15:0] d);
    @(posedge clk_sys);
    status_wr <= '{en: 1'b1, be: be, data: d};
    @(posedge clk_sys);
    status_wr.en <= 1'b0;
  endtask
  task automatic wr_pr(logic [7:0] d);
    @(posedge clk_sys);
    preset_wr <= '{en: 1'b1, data: d};
    @(posedge clk_sys);
    preset_wr.en <= 1'b0;
  endtask
  task automatic exp(int sel, logic [15:0] v);
    notes.push_back('{sel, v});
  endtask
  // bounded wait for irq, sampled once the edge has settled
  task automatic wait_irq(int lim);
    t0 = 0;
    while (irq !== 1'b1 && t0 < lim) begin
      @(posedge clk_sys);
      #1;
      t0++;
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // scoreboard: notes are taken off mid-cycle, where outputs are settled
  always @(negedge clk_sys) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      seen = nt.sel == 0 ? status_rd : nt.sel == 1 ? {8'h0, preset_rd} :
        nt.sel == 2 ? {8'h0, counter_rd} : {15'h0, irq};
      n_compared++;
      if (seen !== nt.v) begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", nm[nt.sel], nt.v, seen);
      end
    end
  end
  // watchdog, far beyond the expected run length
  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'h485a));
    cyc(6);
    rst <= 1'b0;
    cyc(3);
    exp(0, 16'h0000);
    exp(3, 16'h0);
    // random byte-lane writes; rate kept at stop so nothing counts
    for (int i = 0; i < 12; i++) begin
      rb = 2'($urandom);
      rv = 16'($urandom);
      wr_st(rb, rv & 16'hfff1);
      if (rb[0]) st_m[7:0] = rv[7:0] & 8'hc1;
      if (rb[1]) st_m[15:8] = rv[15:8] & 8'hc1;
      cyc(3);
      exp(0, st_m);
      exp(3, {15'h0, (st_m[15] & st_m[14]) | (st_m[7] & st_m[6])});
    end
    wr_st(2'b11, 16'hffff);
    cyc(3);
    exp(0, 16'hc1cf);
    wr_st(2'b11, 16'h0);
    $display("test register access done");
    wr_pr(8'hfe);
    cyc(3);
    exp(1, 16'hfe);
    exp(2, 16'hfe);
    wr_st(2'b01, 16'h0002);
    wr_st(2'b10, 16'h0800);
    cyc(3);
    exp(2, 16'hff);
    wr_pr(8'h10);
    wr_st(2'b01, 16'h0004);
    repeat (2) wr_st(2'b10, 16'h0800);
    cyc(3);
    exp(2, 16'h11);
    exp(0, 16'h0004);
    $display("test maintenance done");
    for (int r = 1; r <= 5; r++) begin
      per = 4 * 2 ** (r - 1);
      wr_pr(8'hfe);
      wr_st(2'b11, 16'h0041 | 16'(r << 1));
      wait_irq(400);
      if (t0 < per + 1 || t0 > 2 * per + 6) begin
        err_count++;
        $display("unexpected overflow time: expected %0d seen %0d", per, t0);
      end
      n_compared++;
      exp(0, 16'h00c0 | 16'(r << 1));
      exp(2, 16'h0);
      exp(3, 16'h1);
      wr_st(2'b11, 16'h0);
      cyc(3);
      exp(3, 16'h0);
    end
    $display("test single interval done");
    wr_pr(8'hfe);
    wr_st(2'b11, 16'h0143);
    wr_pr(8'h80);
    wait_irq(40);
    exp(2, 16'h80);
    exp(0, 16'h01c3);
    exp(1, 16'h80);
    wr_st(2'b11, 16'h0);
    $display("test repeated interval done");
    // first burst with enable clear, second with enable set; both overflow
    wr_pr(8'hfe);
    for (int e = 0; e < 2; e++) begin
      wr_st(2'b11, 16'h400c | 16'(e));
      ext_go <= 1'b1;
      cyc(1);
      ext_go <= 1'b0;
      cyc(30);
      exp(2, e ? 16'hfe : 16'hff);
      exp(0, 16'hc08c | 16'(e));
      exp(3, 16'h1);
    end
    wr_st(2'b11, 16'h0);
    $display("test external done");
    wr_pr(8'h20);
    for (int k = 1; k >= 0; k--) begin
      wr_st(2'b11, k ? 16'h000f : 16'h0001);
      cyc(40);
      exp(2, 16'h20);
    end
    // auxiliary pin: three rising edges, three counts
    wr_st(2'b11, 16'h000f);
    repeat (6) begin
      cyc(4);
      aux_rate_pin <= ~aux_rate_pin;
    end
    cyc(8);
    exp(2, 16'h23);
    $display("test stopped rates done");
    cyc(2);
    conclude();
  end
endmodule
